// file: design/io_wdog_map.vh
// register offsets, field positions, reset values and timing counts
`ifndef IO_WDOG_MAP_VH
`define IO_WDOG_MAP_VH

// register offsets on the local command port
`define OFS_INIT      8'h00
`define OFS_DIR       8'h04
`define OFS_PATTERN   8'h08
`define OFS_READBACK  8'h0C
`define OFS_STATUS    8'h10
`define OFS_OCUR      8'h14
`define OFS_WD_CFG    8'h18
`define OFS_WD_RELOAD 8'h1C
`define OFS_WD_COUNT  8'h20

// error status bit positions
`define ST_PARITY     0
`define ST_OVERRUN    1
`define ST_TIMEOUT    2
`define ST_WD_EXPIRED 3
`define ST_OT_LOW     6
`define ST_OT_HIGH    7

// watchdog configuration word
`define WD_EN_BIT     31
`define WD_TIME_W     17
`define WD_TIME_MAX   17'h1A36E
`define WD_START_RST  17'h0000A

// answer when the module is not the one addressed
`define RD_NO_MODULE  32'hFFFFFFFF

// module address range
`define MOD_ADDR_MIN  4'h1
`define MOD_ADDR_MAX  4'hF

// timing
`define CLK_PERIOD_NS 8
`define WD_TICK_NS    1000000
`define IN_FILT_NS    12000
`define WD_TICK_CYC   (`WD_TICK_NS / `CLK_PERIOD_NS)
`define IN_FILT_CYC   ((`IN_FILT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_ONLY_CYC 1

`endif

// file: design/pin_sync_filter.v
// three-stage pin synchroniser with per-channel settle filter
`timescale 1ns/10ps
`default_nettype none

module pin_sync_filter #(
    parameter WIDTH    = 32,
    parameter FILT_CYC = 1500,
    parameter CW       = 11
) (
    // clock and reset
    input  wire             mclk,
    input  wire             rst_n,
    input  wire             ce,
    // pins
    input  wire [WIDTH-1:0] pin_in,
    // synchronised and filtered levels
    output reg  [WIDTH-1:0] lvl_ff,
    output reg  [WIDTH-1:0] filt_ff
);

    localparam integer  LAST_I = FILT_CYC - 1;
    localparam [CW-1:0] LAST   = LAST_I[CW-1:0];

    reg [WIDTH-1:0] s1_ff;
    reg [WIDTH-1:0] s2_ff;
    reg [WIDTH-1:0] s3_ff;
    reg [CW-1:0]    cnt_ff [0:WIDTH-1];
    integer         i;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff   <= {WIDTH{1'b0}};
            s2_ff   <= {WIDTH{1'b0}};
            s3_ff   <= {WIDTH{1'b0}};
            lvl_ff  <= {WIDTH{1'b0}};
            filt_ff <= {WIDTH{1'b0}};
            for (i = 0; i < WIDTH; i = i + 1) begin
                cnt_ff[i] <= {CW{1'b0}};
            end
        end else if (ce) begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (i = 0; i < WIDTH; i = i + 1) begin
                // change counts once stages two and three agree
                if (s2_ff[i] == s3_ff[i]) begin
                    lvl_ff[i] <= s3_ff[i];
                end
                if (lvl_ff[i] == filt_ff[i]) begin
                    cnt_ff[i] <= {CW{1'b0}};
                end else if (cnt_ff[i] >= LAST) begin
                    filt_ff[i] <= lvl_ff[i];
                    cnt_ff[i]  <= {CW{1'b0}};
                end else begin
                    cnt_ff[i] <= cnt_ff[i] + {{(CW-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule // pin_sync_filter

`default_nettype wire

// file: design/io_wdog_module.v
// digital i/o module core: watchdog, channel drive, readback, status
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "io_wdog_map.vh"

module io_wdog_module #(
    parameter NCH         = 32,
    parameter WD_TICK_CYC = `WD_TICK_CYC,
    parameter FILT_CYC    = `IN_FILT_CYC,
    parameter TICK_W      = 17,
    parameter FILT_W      = 11
) (
    // clock, reset, clock enable
    input  wire             mclk,
    input  wire             rst_n,
    input  wire             ce,
    // module address strap
    input  wire [3:0]       mod_addr_strap,
    // command port
    input  wire [3:0]       cmd_mod,
    input  wire             cmd_bcast,
    input  wire [7:0]       addr,
    input  wire [31:0]      wdata,
    input  wire             wr,
    input  wire             rd,
    output reg  [31:0]      rdata_ff,
    // bus transfer error pulses from framing logic
    input  wire             err_parity,
    input  wire             err_overrun,
    input  wire             err_timeout,
    // channel pins
    input  wire [NCH-1:0]   ch_pin_in,
    output reg  [NCH-1:0]   ch_pin_out_ff,
    output reg  [NCH-1:0]   ch_pin_oe_ff,
    // driver fault sense pins
    input  wire [NCH-1:0]   oc_sense,
    input  wire             ot_low_sense,
    input  wire             ot_high_sense,
    // watchdog state
    output wire             watchdog_expired_flag
);

    localparam integer      TICK_LAST_I = WD_TICK_CYC - 1;
    localparam [TICK_W-1:0] TICK_LAST   = TICK_LAST_I[TICK_W-1:0];
    localparam HALF = NCH / 2;

    ////////////////////////////////////////////////////////////////////
    // helpers

    function [31:0] zext_time;
        input [`WD_TIME_W-1:0] t;
        begin
            zext_time = {{(32-`WD_TIME_W){1'b0}}, t};
        end
    endfunction

    function [`WD_TIME_W-1:0] clip_time;
        input [31:0] w;
        begin
            if (w[`WD_TIME_W-1:0] > `WD_TIME_MAX || |w[30:`WD_TIME_W])
                clip_time = `WD_TIME_MAX;
            else
                clip_time = w[`WD_TIME_W-1:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers

    wire [NCH-1:0] ch_lvl;
    wire [NCH-1:0] ch_filt;
    wire [NCH-1:0] oc_lvl;
    wire [1:0]     ot_lvl;

    pin_sync_filter #(
        .WIDTH    (NCH),
        .FILT_CYC (FILT_CYC),
        .CW       (FILT_W)
    ) u_ch_sync (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .ce      (ce),
        .pin_in  (ch_pin_in),
        .lvl_ff  (ch_lvl),
        .filt_ff (ch_filt)
    );

    pin_sync_filter #(
        .WIDTH    (NCH + 2),
        .FILT_CYC (`SYNC_ONLY_CYC),
        .CW       (1)
    ) u_fault_sync (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .ce      (ce),
        .pin_in  ({ot_high_sense, ot_low_sense, oc_sense}),
        .lvl_ff  ({ot_lvl, oc_lvl}),
        .filt_ff ()
    );

    ////////////////////////////////////////////////////////////////////
    // address strap capture after reset release

    reg [3:0] my_addr_ff;
    reg       addr_taken_ff;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            my_addr_ff    <= 4'h0;
            addr_taken_ff <= 1'b0;
        end else if (ce && !addr_taken_ff) begin
            my_addr_ff    <= mod_addr_strap;
            addr_taken_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // command decode

    wire addr_valid = addr_taken_ff && (my_addr_ff >= `MOD_ADDR_MIN);
    wire mine       = addr_valid && !cmd_bcast && (cmd_mod == my_addr_ff);
    wire wr_me      = ce && wr && mine;
    wire rd_me      = ce && rd && mine;
    wire bcast_rld  = ce && wr && cmd_bcast && addr == `OFS_WD_RELOAD;
    wire do_init    = wr_me && addr == `OFS_INIT;
    wire do_wd_cfg  = wr_me && addr == `OFS_WD_CFG;
    wire do_reload  = (wr_me || rd_me || bcast_rld) && !do_wd_cfg;

    ////////////////////////////////////////////////////////////////////
    // channel configuration

    reg  [NCH-1:0] dir_ff;
    reg  [NCH-1:0] pattern_ff;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dir_ff     <= {NCH{1'b0}};
            pattern_ff <= {NCH{1'b0}};
        end else if (do_init) begin
            dir_ff     <= {NCH{1'b0}};
            pattern_ff <= {NCH{1'b0}};
        end else begin
            if (wr_me && addr == `OFS_DIR)
                dir_ff <= wdata[NCH-1:0];
            if (wr_me && addr == `OFS_PATTERN)
                pattern_ff <= wdata[NCH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // watchdog

    reg                  wd_en_ff;
    reg [`WD_TIME_W-1:0] wd_start_ff;
    reg [`WD_TIME_W-1:0] wd_cnt_ff;
    reg [TICK_W-1:0]     tick_cnt_ff;
    reg                  wd_exp_ff;
    wire                 ms_tick = (tick_cnt_ff == TICK_LAST);
    wire                 hit_zero;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_ff <= {TICK_W{1'b0}};
        end else if (ce) begin
            if (ms_tick || do_reload || do_wd_cfg)
                tick_cnt_ff <= {TICK_W{1'b0}};
            else
                tick_cnt_ff <= tick_cnt_ff + {{(TICK_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wd_en_ff    <= 1'b1;
            wd_start_ff <= `WD_START_RST;
            wd_cnt_ff   <= `WD_START_RST;
        end else if (do_wd_cfg) begin
            wd_en_ff <= wdata[`WD_EN_BIT];
            if (wdata[`WD_EN_BIT]) begin
                wd_start_ff <= clip_time(wdata);
                wd_cnt_ff   <= clip_time(wdata);
            end
        end else if (do_reload) begin
            wd_cnt_ff <= wd_start_ff;
        end else if (ce && wd_en_ff && ms_tick && wd_cnt_ff != 0) begin
            wd_cnt_ff <= wd_cnt_ff - {{(`WD_TIME_W-1){1'b0}}, 1'b1};
        end
    end

    assign hit_zero = wd_en_ff && wd_cnt_ff == 0 && !do_reload && !do_wd_cfg;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            wd_exp_ff <= 1'b0;
        else if (ce && hit_zero)
            wd_exp_ff <= 1'b1;
        else if (do_init)
            wd_exp_ff <= 1'b0;
    end

    assign watchdog_expired_flag = wd_exp_ff;

    ////////////////////////////////////////////////////////////////////
    // driver faults

    reg [NCH-1:0] oc_off_ff;
    reg           ot_low_ff;
    reg           ot_high_ff;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            oc_off_ff  <= {NCH{1'b0}};
            ot_low_ff  <= 1'b0;
            ot_high_ff <= 1'b0;
        end else if (ce) begin
            // set wins over initialise
            oc_off_ff  <= (do_init ? {NCH{1'b0}} : oc_off_ff)
                          | (oc_lvl & dir_ff);
            ot_low_ff  <= (ot_low_ff & ~do_init) | ot_lvl[0];
            ot_high_ff <= (ot_high_ff & ~do_init) | ot_lvl[1];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus transfer errors

    reg [2:0] xfer_err_ff;
    wire      st_read = rd_me && addr == `OFS_STATUS;
    wire [2:0] xfer_set = {err_timeout, err_overrun, err_parity};

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            xfer_err_ff <= 3'h0;
        else if (ce)
            // read clears, a new error in that cycle still lands
            xfer_err_ff <= ((st_read || do_init) ? 3'h0 : xfer_err_ff)
                           | xfer_set;
    end

    ////////////////////////////////////////////////////////////////////
    // channel drive

    reg  [NCH-1:0] grp_off;
    wire           halted = wd_exp_ff;

    always @* begin
        grp_off = {NCH{1'b0}};
        grp_off[HALF-1:0]   = {HALF{ot_low_ff}};
        grp_off[NCH-1:HALF] = {HALF{ot_high_ff}};
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ch_pin_out_ff <= {NCH{1'b0}};
            ch_pin_oe_ff  <= {NCH{1'b0}};
        end else if (ce) begin
            if (halted) begin
                ch_pin_out_ff <= {NCH{1'b0}};
                ch_pin_oe_ff  <= {NCH{1'b0}};
            end else begin
                ch_pin_out_ff <= pattern_ff & dir_ff;
                ch_pin_oe_ff  <= dir_ff & ~oc_off_ff & ~grp_off;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // readback and status

    reg  [31:0] status_word;
    reg  [31:0] rd_mux;
    wire [NCH-1:0] readback = (dir_ff & ch_lvl) | (~dir_ff & ch_filt);

    always @* begin
        status_word = 32'h0;
        status_word[`ST_PARITY]     = xfer_err_ff[0];
        status_word[`ST_OVERRUN]    = xfer_err_ff[1];
        status_word[`ST_TIMEOUT]    = xfer_err_ff[2];
        status_word[`ST_WD_EXPIRED] = wd_exp_ff;
        status_word[`ST_OT_LOW]     = ot_low_ff;
        status_word[`ST_OT_HIGH]    = ot_high_ff;
    end

    always @* begin
        rd_mux = 32'h0;
        case (addr)
            `OFS_DIR:      rd_mux[NCH-1:0] = dir_ff;
            `OFS_PATTERN:  rd_mux[NCH-1:0] = pattern_ff;
            `OFS_READBACK: rd_mux[NCH-1:0] = readback;
            `OFS_STATUS:   rd_mux = status_word;
            `OFS_OCUR:     rd_mux[NCH-1:0] = oc_off_ff;
            `OFS_WD_CFG: begin
                rd_mux = zext_time(wd_start_ff);
                rd_mux[`WD_EN_BIT] = wd_en_ff;
            end
            `OFS_WD_COUNT: rd_mux = zext_time(wd_cnt_ff);
            default:       rd_mux = 32'h0;
        endcase
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            rdata_ff <= 32'h0;
        else if (ce) begin
            if (rd_me)
                rdata_ff <= rd_mux;
            else if (rd)
                rdata_ff <= `RD_NO_MODULE;
            else
                rdata_ff <= 32'h0;
        end
    end

endmodule // io_wdog_module

`default_nettype wire

// file: tb/io_wdog_props.sv
// assertion checker bound to the i/o module core ports
`timescale 1ns/10ps
`default_nettype none
`include "io_wdog_map.vh"

module io_wdog_props #(
    parameter NCH = 32
) (
    // clock and reset
    input wire logic           mclk,
    input wire logic           rst_n,
    // command port
    input wire logic [3:0]     mod_addr_strap,
    input wire logic [3:0]     cmd_mod,
    input wire logic           cmd_bcast,
    input wire logic [7:0]     addr,
    input wire logic [31:0]    wdata,
    input wire logic           wr,
    input wire logic           rd,
    input wire logic [31:0]    rdata_ff,
    input wire logic           err_parity,
    // pins, faults, watchdog
    input wire logic [NCH-1:0] ch_pin_out_ff,
    input wire logic [NCH-1:0] ch_pin_oe_ff,
    input wire logic [NCH-1:0] oc_sense,
    input wire logic           ot_low_sense,
    input wire logic           ot_high_sense,
    input wire logic           watchdog_expired_flag
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire own = !cmd_bcast && (cmd_mod == mod_addr_strap);
    ////////////////////////////////////////////////////////////////////////////////
    sequence st_rd;
        own && rd && (addr == `OFS_STATUS);
    endsequence
    sequence init_wr;
        own && wr && (addr == `OFS_INIT);
    endsequence
    sequence pat_wr;
        own && wr && (addr == `OFS_PATTERN);
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_rd_other_mod: assert property (rd && !own |=> rdata_ff == 32'hFFFFFFFF)
        else $error("read of another module did not answer all ones");
    a_rdata_idle: assert property (!rd |=> rdata_ff == 32'h0)
        else $error("read data not zero outside answer cycle");
    a_parity_seen: assert property (err_parity ##[1:3] st_rd |=> rdata_ff[`ST_PARITY])
        else $error("parity error not shown in status");
    a_expired_stat: assert property (st_rd ##0 watchdog_expired_flag |=> rdata_ff[3])
        else $error("expired watchdog not shown in status");
    a_expired_off: assert property (watchdog_expired_flag |=> (ch_pin_oe_ff == 0) && (ch_pin_out_ff == 0))
        else $error("drivers not off after watchdog expiry");
    a_ot_low_off: assert property (ot_low_sense |-> ##[1:8] ch_pin_oe_ff[15:0] == 16'h0)
        else $error("low driver half not off on overtemp");
    a_ot_high_off: assert property (ot_high_sense |-> ##[1:8] ch_pin_oe_ff[31:16] == 16'h0)
        else $error("high driver half not off on overtemp");
    a_oc_chan_off: assert property ((oc_sense & ch_pin_oe_ff) != 0 |-> ##[1:8] (oc_sense & ch_pin_oe_ff) == 0)
        else $error("over-current channel not switched off");
    a_init_clears: assert property (init_wr |=> ##1 (ch_pin_oe_ff == 0) && !watchdog_expired_flag)
        else $error("initialise did not clear drivers and expiry");
    a_pattern_out: assert property (pat_wr |=> ##1 watchdog_expired_flag
        || ((ch_pin_out_ff & ch_pin_oe_ff) == ($past(wdata, 2) & ch_pin_oe_ff)))
        else $error("pattern not applied to output channels");
endmodule // io_wdog_props

bind io_wdog_module io_wdog_props #(.NCH(NCH)) u_props (
    .mclk(mclk), .rst_n(rst_n), .mod_addr_strap(mod_addr_strap), .cmd_mod(cmd_mod),
    .cmd_bcast(cmd_bcast), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff),
    .err_parity(err_parity), .ch_pin_out_ff(ch_pin_out_ff), .ch_pin_oe_ff(ch_pin_oe_ff),
    .oc_sense(oc_sense), .ot_low_sense(ot_low_sense), .ot_high_sense(ot_high_sense),
    .watchdog_expired_flag(watchdog_expired_flag)
);
`default_nettype wire

// file: tb/ch_load_model.sv
// field-side model of the channel pins: sources inputs, loads outputs
`timescale 1ns/10ps
`default_nettype none

module ch_load_model (
    // from the module
    input  wire logic [31:0] ch_pin_out_ff,
    input  wire logic [31:0] ch_pin_oe_ff,
    // field conditions
    input  wire logic [31:0] ext_lvl,
    input  wire logic [31:0] overload,
    // to the module
    output wire logic [31:0] ch_pin_in,
    output wire logic [31:0] oc_sense
);
    // driven channels show the drive, the others the field level
    assign ch_pin_in = (ch_pin_oe_ff & ch_pin_out_ff) | (~ch_pin_oe_ff & ext_lvl);
    // current flows only while a channel drives high into an overload
    assign oc_sense = ch_pin_oe_ff & ch_pin_out_ff & overload;
endmodule // ch_load_model
`default_nettype wire

// file: tb/io_wdog_module_tb_top.sv
// testbench for the i/o module core
`timescale 1ns/10ps
`default_nettype none
`include "io_wdog_map.vh"

module io_wdog_module_tb_top;
    logic        mclk      = 1'h0;
    logic        rst_n     = 1'h0;
    logic [3:0]  cmd_mod   = 4'h1;
    logic        cmd_bcast = 1'h0;
    logic [7:0]  addr      = 8'h00;
    logic [31:0] wdata     = 32'h0;
    logic        wr        = 1'h0;
    logic        rd        = 1'h0;
    logic [2:0]  err       = 3'h0;
    logic        ot_lo     = 1'h0;
    logic        ot_hi     = 1'h0;
    logic [31:0] ext_lvl   = 32'h0;
    logic [31:0] overload  = 32'h0;
    wire  [31:0] rdata_ff, ch_pin_in, ch_pin_out_ff, ch_pin_oe_ff, oc_sense;
    wire         watchdog_expired_flag;
    int          n_fail     = 0;
    int          n_compared = 0;
    int          i;

    io_wdog_module #(.WD_TICK_CYC(20), .FILT_CYC(4)) DUT (
        .mclk(mclk), .rst_n(rst_n), .ce(1'h1), .mod_addr_strap(4'h1), .cmd_mod(cmd_mod),
        .cmd_bcast(cmd_bcast), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_ff(rdata_ff), .err_parity(err[0]), .err_overrun(err[1]), .err_timeout(err[2]),
        .ch_pin_in(ch_pin_in), .ch_pin_out_ff(ch_pin_out_ff), .ch_pin_oe_ff(ch_pin_oe_ff),
        .oc_sense(oc_sense), .ot_low_sense(ot_lo), .ot_high_sense(ot_hi),
        .watchdog_expired_flag(watchdog_expired_flag)
    );
    ch_load_model u_load (
        .ch_pin_out_ff(ch_pin_out_ff), .ch_pin_oe_ff(ch_pin_oe_ff), .ext_lvl(ext_lvl),
        .overload(overload), .ch_pin_in(ch_pin_in), .oc_sense(oc_sense)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        if (n_fail == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask
    task automatic chk_flag(input logic e);
        chk({31'h0, watchdog_expired_flag}, {31'h0, e});
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic b = 1'h0);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        cmd_bcast <= b;
        wr <= 1'h1;
        @(posedge mclk);
        wr <= 1'h0;
        cmd_bcast <= 1'h0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input logic [31:0] msk = 32'hFFFFFFFF, input logic [3:0] m = 4'h1);
        @(posedge mclk);
        addr <= a;
        cmd_mod <= m;
        rd <= 1'h1;
        @(posedge mclk);
        rd <= 1'h0;
        cmd_mod <= 4'h1;
        #1 chk(rdata_ff & msk, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #4 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        test_done;
    end
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'h1;
        idle(2);
        chk(ch_pin_oe_ff, 32'h0);
        idle(170);
        chk_flag(1'h0);
        idle(50);
        chk_flag(1'h1);
        chk(ch_pin_out_ff | ch_pin_oe_ff, 32'h0);
        rd_chk(`OFS_STATUS, 32'h8, 32'hCF);
        wr_reg(`OFS_WD_RELOAD, 32'h0, 1'h1);
        idle(3);
        chk_flag(1'h1);
        wr_reg(`OFS_INIT, 32'h0);
        rd_chk(`OFS_STATUS, 32'h0, 32'hCF);
        rd_chk(`OFS_WD_COUNT, 32'hA);
        rd_chk(`OFS_STATUS, 32'hFFFFFFFF, 32'hFFFFFFFF, 4'h2);
        for (i = 0; i < 3; i++) begin
            @(posedge mclk);
            err <= 3'h1 << i;
            @(posedge mclk);
            err <= 3'h0;
            rd_chk(`OFS_STATUS, 32'h1 << i, 32'hCF);
            rd_chk(`OFS_STATUS, 32'h0, 32'hCF);
        end
        // half outputs, half inputs
        ext_lvl <= 32'hA5A50000;
        wr_reg(`OFS_DIR, 32'h0000FFFF);
        wr_reg(`OFS_PATTERN, 32'h12345678);
        idle(20);
        chk(ch_pin_oe_ff, 32'h0000FFFF);
        chk(ch_pin_out_ff & ch_pin_oe_ff, 32'h00005678);
        rd_chk(`OFS_READBACK, 32'hA5A55678);
        ext_lvl <= 32'h5A5A0000;
        rd_chk(`OFS_READBACK, 32'hA5A55678);
        idle(20);
        rd_chk(`OFS_READBACK, 32'h5A5A5678);
        overload <= 32'h8;
        idle(12);
        rd_chk(`OFS_OCUR, 32'h8);
        chk(ch_pin_oe_ff, 32'h0000FFF7);
        ot_lo <= 1'h1;
        idle(12);
        rd_chk(`OFS_STATUS, 32'h40, 32'hCF);
        chk(ch_pin_oe_ff, 32'h0);
        ot_lo <= 1'h0;
        // upper half driving when its driver overheats
        wr_reg(`OFS_DIR, 32'hFFFFFFFF);
        ot_hi <= 1'h1;
        idle(12);
        rd_chk(`OFS_STATUS, 32'hC0, 32'hCF);
        chk(ch_pin_oe_ff, 32'h0);
        ot_hi <= 1'h0;
        overload <= 32'h0;
        // let the sense pins settle through the synchroniser first
        idle(8);
        wr_reg(`OFS_INIT, 32'h0);
        rd_chk(`OFS_STATUS, 32'h0, 32'hCF);
        rd_chk(`OFS_OCUR, 32'h0);
        wr_reg(`OFS_DIR, 32'hFFFFFFFF);
        wr_reg(`OFS_PATTERN, 32'h0000FFFF);
        // 3 ms window kept alive by broadcast and by addressed reads
        wr_reg(`OFS_WD_CFG, 32'h80000003);
        for (i = 0; i < 4; i++) begin
            idle(40);
            wr_reg(`OFS_WD_RELOAD, 32'h0, 1'h1);
        end
        for (i = 0; i < 3; i++) begin
            idle(40);
            rd_chk(`OFS_PATTERN, 32'h0000FFFF);
        end
        chk_flag(1'h0);
        chk(ch_pin_oe_ff, 32'hFFFFFFFF);
        idle(40);
        chk_flag(1'h0);
        idle(40);
        chk_flag(1'h1);
        chk(ch_pin_out_ff | ch_pin_oe_ff, 32'h0);
        wr_reg(`OFS_INIT, 32'h0);
        wr_reg(`OFS_WD_CFG, 32'h00000003);
        idle(200);
        chk_flag(1'h0);
        wr_reg(`OFS_WD_RELOAD, 32'h0, 1'h1);
        idle(200);
        chk_flag(1'h0);
        wr_reg(`OFS_WD_CFG, 32'h80000000);
        idle(4);
        chk_flag(1'h1);
        wr_reg(`OFS_WD_CFG, 32'h8001FFFF);
        wr_reg(`OFS_INIT, 32'h0);
        rd_chk(`OFS_WD_COUNT, 32'h0001A36E);
        test_done;
    end
endmodule // io_wdog_module_tb_top
`default_nettype wire
